// ===== hdl/dacc_code_form.sv
// Forms the converter code from the data bytes and width mode
`timescale 1ns/1ps
module dacc_code_form (
    // Mode and data
    input  wire logic                        i_narrow_mode,
    input  wire logic [dacc_pkg::SFR_DW-1:0] i_low,
    input  wire logic [dacc_pkg::NIB_W-1:0]  i_high_nib,
    // Code
    output logic      [dacc_pkg::CODE_W-1:0] o_code
);
    import dacc_pkg::*;

    wire logic [CODE_W-1:0] wide_code;
    wire logic [CODE_W-1:0] narrow_code;

    assign wide_code   = {i_high_nib, i_low};
    assign narrow_code = {i_low, {NIB_W{1'b0}}};
    assign o_code      = i_narrow_mode ? narrow_code : wide_code;

endmodule // dacc_code_form

// ===== hdl/dacc_control.sv
// Converter control and data registers on the special function bus
`timescale 1ns/1ps
module dacc_control (
    // Clock and reset
    input  wire logic                        i_core_clk,
    input  wire logic                        i_reset_n,
    // Special function register bus
    input  wire logic [dacc_pkg::SFR_AW-1:0] i_sfr_addr,
    input  wire logic                        i_sfr_wr,
    input  wire logic [dacc_pkg::SFR_DW-1:0] i_sfr_wdata,
    input  wire logic                        i_sfr_rd,
    output logic      [dacc_pkg::SFR_DW-1:0] o_sfr_rdata,
    // Converter
    output logic      [dacc_pkg::CODE_W-1:0] o_converter_code,
    output logic                             o_converter_enable,
    output logic                             o_output_range_select,
    output logic                             o_output_pin_select,
    output logic                             o_pin_default_oe,
    output logic                             o_pin_alt_oe
);
    import dacc_pkg::*;

    // =================================================================
    // Helpers

    // Register select for one special function address
    function automatic logic addr_match(
        input logic [SFR_AW-1:0] addr,
        input logic [SFR_AW-1:0] target
    );
        return addr == target;
    endfunction

    // Converter powered and routed to the default pin
    function automatic logic drive_default(
        input logic [SFR_DW-1:0] control
    );
        return control[BIT_ENABLE] && !control[BIT_PIN_SELECT];
    endfunction

    // Converter powered and routed to the alternate pin
    function automatic logic drive_alt(
        input logic [SFR_DW-1:0] control
    );
        return control[BIT_ENABLE] && control[BIT_PIN_SELECT];
    endfunction

    // =================================================================
    // Registers
    logic [SFR_DW-1:0] converter_control;
    logic [SFR_DW-1:0] converter_code_low;
    logic [SFR_DW-1:0] converter_code_high;

    // =================================================================
    // Decode
    wire logic wr_low;
    wire logic wr_high;
    wire logic wr_ctrl;
    wire logic hit_low;
    wire logic hit_high;
    wire logic hit_ctrl;

    assign hit_low  = addr_match(i_sfr_addr, ADDR_CODE_LOW);
    assign hit_high = addr_match(i_sfr_addr, ADDR_CODE_HIGH);
    assign hit_ctrl = addr_match(i_sfr_addr, ADDR_CONTROL);
    assign wr_low   = i_sfr_wr && hit_low;
    assign wr_high  = i_sfr_wr && hit_high;
    assign wr_ctrl  = i_sfr_wr && hit_ctrl;

    // =================================================================
    // Control values in effect next cycle
    wire logic [SFR_DW-1:0] next_control;
    wire logic              next_clear_n;
    wire logic              next_narrow;
    wire logic              next_enable;
    wire logic              next_pin_alt;

    assign next_control = wr_ctrl ? (i_sfr_wdata & CONTROL_MASK)
                                  : converter_control;
    assign next_clear_n = next_control[BIT_CLEAR_N];
    assign next_narrow  = next_control[BIT_NARROW_MODE];
    assign next_enable  = next_control[BIT_ENABLE];
    assign next_pin_alt = next_control[BIT_PIN_SELECT];

    // =================================================================
    // Data registers
    wire logic [SFR_DW-1:0] next_code_low;
    wire logic [SFR_DW-1:0] next_code_high;

    // Held at zero while clear is active, writes dropped
    assign next_code_low  = !next_clear_n ? RST_CODE_LOW
                          : wr_low ? i_sfr_wdata
                          : converter_code_low;
    assign next_code_high = !next_clear_n ? RST_CODE_HIGH
                          : wr_high ? i_sfr_wdata
                          : converter_code_high;

    // =================================================================
    // Code presented to the converter
    wire logic [CODE_W-1:0] formed_code;
    wire logic              code_load;
    wire logic [CODE_W-1:0] next_code;

    dacc_code_form u_code_form (
        .i_narrow_mode (next_narrow),
        .i_low         (next_code_low),
        .i_high_nib    (next_code_high[NIB_W-1:0]),
        .o_code        (formed_code)
    );

    // High byte alone only stages; low byte or control write applies
    assign code_load = wr_low || wr_ctrl;
    assign next_code = !next_clear_n ? RST_CODE :
                       code_load ? formed_code : o_converter_code;

    // =================================================================
    // Read path
    wire logic [SFR_DW-1:0] read_mux;

    assign read_mux = hit_low  ? converter_code_low  :
                      hit_high ? converter_code_high :
                      hit_ctrl ? converter_control   : READ_UNMAPPED;

    // =================================================================
    // Output values in effect next cycle
    wire logic              next_range;
    wire logic              next_default_oe;
    wire logic              next_alt_oe;
    wire logic [SFR_DW-1:0] next_rdata;

    assign next_range      = next_control[BIT_RANGE];
    // Pin floats unless enabled
    assign next_default_oe = drive_default(next_control);
    assign next_alt_oe     = drive_alt(next_control);
    // Read data holds between reads
    assign next_rdata      = i_sfr_rd ? read_mux : o_sfr_rdata;

    // =================================================================
    // Control register
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            converter_control <= RST_CONTROL;
        end else begin
            converter_control <= next_control;
        end
    end

    // =================================================================
    // Data registers
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            converter_code_low <= RST_CODE_LOW;
        end else begin
            converter_code_low <= next_code_low;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            converter_code_high <= RST_CODE_HIGH;
        end else begin
            converter_code_high <= next_code_high;
        end
    end

    // =================================================================
    // Converter code
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_converter_code <= RST_CODE;
        end else begin
            o_converter_code <= next_code;
        end
    end

    // =================================================================
    // Converter enable
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_converter_enable <= RST_CONTROL[BIT_ENABLE];
        end else begin
            o_converter_enable <= next_enable;
        end
    end

    // =================================================================
    // Output range
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_output_range_select <= RST_CONTROL[BIT_RANGE];
        end else begin
            o_output_range_select <= next_range;
        end
    end

    // =================================================================
    // Output pin select
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_output_pin_select <= RST_CONTROL[BIT_PIN_SELECT];
        end else begin
            o_output_pin_select <= next_pin_alt;
        end
    end

    // =================================================================
    // Pin drive enables
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_pin_default_oe <= drive_default(RST_CONTROL);
            o_pin_alt_oe     <= drive_alt(RST_CONTROL);
        end else begin
            o_pin_default_oe <= next_default_oe;
            o_pin_alt_oe     <= next_alt_oe;
        end
    end

    // =================================================================
    // Read data
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_sfr_rdata <= READ_UNMAPPED;
        end else begin
            o_sfr_rdata <= next_rdata;
        end
    end

endmodule // dacc_control

// ===== pkg/dacc_pkg.sv
// Constants for the converter control register block
// =====================================================================
// What this block does
// - Control bit 4 set routes output to alternate pin, clear to default.
// - Bit 3 set: low byte drives 8 MSBs, 4 LSBs zero; else 12-bit.
// - Control bit 2 picks range: set supply span, clear reference span.
// - While control bit 1 is zero both data registers held at zero.
// - Bit 0 one enables converter; zero powers down, output high-impedance.
// - Low data at FBH, high data at FCH, both reset to 00H.
// - After reset converter stays disabled and high-impedance until enabled.
// - In 12-bit mode the code applies when low byte is written.
// - In 12-bit mode code right-justified: low byte bits 7:0, high nibble bits 11:8.
package dacc_pkg;

    // =================================================================
    // Widths
    localparam int SFR_AW  = 8;
    localparam int SFR_DW  = 8;
    localparam int CODE_W  = 12;
    localparam int NIB_W   = 4;

    // =================================================================
    // Addresses
    localparam logic [SFR_AW-1:0] ADDR_CODE_LOW  = 8'hfb;
    localparam logic [SFR_AW-1:0] ADDR_CODE_HIGH = 8'hfc;
    localparam logic [SFR_AW-1:0] ADDR_CONTROL   = 8'hf9;

    // =================================================================
    // Control field positions
    localparam int BIT_PIN_SELECT  = 4;
    localparam int BIT_NARROW_MODE = 3;
    localparam int BIT_RANGE       = 2;
    localparam int BIT_CLEAR_N     = 1;
    localparam int BIT_ENABLE      = 0;

    // Implemented control bits; the rest read zero
    localparam logic [SFR_DW-1:0] CONTROL_MASK = 8'h1f;

    // =================================================================
    // Reset values
    localparam logic [SFR_DW-1:0] RST_CODE_LOW  = 8'h00;
    localparam logic [SFR_DW-1:0] RST_CODE_HIGH = 8'h00;
    localparam logic [SFR_DW-1:0] RST_CONTROL   = 8'h00;
    localparam logic [SFR_DW-1:0] READ_UNMAPPED = 8'h00;
    localparam logic [CODE_W-1:0] RST_CODE      = 12'h000;

endpackage

// ===== tb/dacc_control_sva.sv
// Assertions on the converter control register block ports
`timescale 1ns/1ps
module dacc_control_sva (
    // Watched ports
    input wire logic                        i_core_clk,
    input wire logic                        i_reset_n,
    input wire logic [dacc_pkg::SFR_AW-1:0] i_sfr_addr,
    input wire logic                        i_sfr_wr,
    input wire logic [dacc_pkg::SFR_DW-1:0] i_sfr_wdata,
    input wire logic                        i_sfr_rd,
    input wire logic [dacc_pkg::SFR_DW-1:0] o_sfr_rdata,
    input wire logic [dacc_pkg::CODE_W-1:0] o_converter_code,
    input wire logic                        o_converter_enable,
    input wire logic                        o_output_range_select,
    input wire logic                        o_output_pin_select,
    input wire logic                        o_pin_default_oe,
    input wire logic                        o_pin_alt_oe
);
    import dacc_pkg::*;
    // =================================================================
    // Shadow of control and high nibble
    logic [7:0] ctl;
    logic [3:0] hi;
    wire wc = i_sfr_wr && i_sfr_addr == ADDR_CONTROL;
    wire wl = i_sfr_wr && i_sfr_addr == ADDR_CODE_LOW;
    wire wh = i_sfr_wr && i_sfr_addr == ADDR_CODE_HIGH;
    wire ru = i_sfr_rd && !(i_sfr_addr inside
        {ADDR_CONTROL, ADDR_CODE_LOW, ADDR_CODE_HIGH});
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) ctl <= 8'h00;
        else if (wc) ctl <= i_sfr_wdata & CONTROL_MASK;
        if (!i_reset_n || !ctl[1]) hi <= 4'h0;
        else if (wh) hi <= i_sfr_wdata[3:0];
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    // =================================================================
    // Assertions
    a_default_pin_oe: assert property (
        o_pin_default_oe == (o_converter_enable && !o_output_pin_select))
        else $error("default pin enable wrong");
    a_alt_pin_oe: assert property (
        o_pin_alt_oe == (o_converter_enable && o_output_pin_select))
        else $error("alternate pin enable wrong");
    a_control_apply: assert property (wc |=>
        o_converter_enable == $past(i_sfr_wdata[BIT_ENABLE])
        && o_output_range_select == $past(i_sfr_wdata[BIT_RANGE])
        && o_output_pin_select == $past(i_sfr_wdata[BIT_PIN_SELECT]))
        else $error("control fields not applied");
    a_narrow_load: assert property (wl && ctl[3] && ctl[1] |=>
        o_converter_code == {$past(i_sfr_wdata), 4'h0})
        else $error("narrow code wrong");
    a_wide_load: assert property (wl && !ctl[3] && ctl[1] |=>
        o_converter_code == {$past(hi), $past(i_sfr_wdata)})
        else $error("wide code wrong");
    a_high_no_apply: assert property (wh |=>
        $stable(o_converter_code)) else $error("high write moved code");
    a_clear_zero: assert property (!ctl[1] |->
        o_converter_code == 12'h000) else $error("code not cleared");
    a_read_control: assert property (
        i_sfr_rd && i_sfr_addr == ADDR_CONTROL |=> o_sfr_rdata == $past(ctl))
        else $error("control read wrong");
    a_read_unmapped: assert property (ru |=> o_sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata))
        else $error("read data moved");
    c_narrow: cover property (wl && ctl[3] && ctl[1]);
    c_wide: cover property (wl && !ctl[3] && ctl[1]);
    c_alt: cover property (o_pin_alt_oe);
    c_clear: cover property (wc && !i_sfr_wdata[1]);
endmodule // dacc_control_sva
bind dacc_control dacc_control_sva chk_u (.i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n), .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr),
    .i_sfr_wdata(i_sfr_wdata), .i_sfr_rd(i_sfr_rd), .o_sfr_rdata(o_sfr_rdata),
    .o_converter_code(o_converter_code),
    .o_converter_enable(o_converter_enable),
    .o_output_range_select(o_output_range_select),
    .o_output_pin_select(o_output_pin_select),
    .o_pin_default_oe(o_pin_default_oe), .o_pin_alt_oe(o_pin_alt_oe));

// ===== tb/testbench.sv
// Self-checking bench for the converter control register block
`timescale 1ns/1ps
module testbench;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [11:0] code;
    logic en, rng, psel, doe, aoe;
    int fails = 0, samples_checked = 0, cyc = 0;
    dacc_control dut_u (.i_core_clk(clk), .i_reset_n(rst_n), .i_sfr_addr(addr),
        .i_sfr_wr(wr), .i_sfr_wdata(wdata), .i_sfr_rd(rd), .o_sfr_rdata(rdata),
        .o_converter_code(code), .o_converter_enable(en),
        .o_output_range_select(rng), .o_output_pin_select(psel),
        .o_pin_default_oe(doe), .o_pin_alt_oe(aoe));
    initial forever #12.5 clk = ~clk;
    // =================================================================
    // Access and compare tasks
    task automatic chk(string n, logic [19:0] e, logic [19:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(logic [7:0] a, logic [7:0] e);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rdata", {12'h000, e}, {12'h000, rdata});
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            end_sim();
        end
    end
    // =================================================================
    // Scenarios
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk("reset", 20'h00000, 20'({en, doe, aoe, rng, psel, code}));
        rd_reg(8'hfb, 8'h00);
        rd_reg(8'hfc, 8'h00);
        wr_reg(8'hfc, 8'h0a);
        rd_reg(8'hfc, 8'h00);
        wr_reg(8'hf9, 8'h03);
        chk("pins", 20'h00018, 20'({en, doe, aoe, rng, psel}));
        wr_reg(8'hfc, 8'hfa);
        chk("code", 20'h00000, 20'(code));
        wr_reg(8'hfb, 8'h5c);
        chk("code", 20'h00a5c, 20'(code));
        rd_reg(8'hfc, 8'hfa);
        wr_reg(8'hf9, 8'hff);
        chk("pins", 20'h00017, 20'({en, doe, aoe, rng, psel}));
        chk("code", 20'h005c0, 20'(code));
        rd_reg(8'hf9, 8'h1f);
        wr_reg(8'hfb, 8'h80);
        chk("code", 20'h00800, 20'(code));
        rd_reg(8'h00, 8'h00);
        wr_reg(8'hf9, 8'h1c);
        chk("clear", 20'h03000, 20'({en, doe, aoe, rng, psel, code}));
        rd_reg(8'hfb, 8'h00);
        rd_reg(8'hfc, 8'h00);
        wr_reg(8'hf9, 8'h03);
        wr_reg(8'hfb, 8'h12);
        chk("code", 20'h00012, 20'(code));
        end_sim();
    end
endmodule // testbench
